// file: design/uerr_pkg.sv
// Package: offsets, field positions, reset values and carriers for the uncorrectable error report block
// Assumes a dword-wide configuration access port of the surrounding bridge
package uerr_pkg;
    localparam logic [11:0] ADDR_CAP_ID = 12'h100;
    localparam logic [11:0] ADDR_NEXT_CAP = 12'h102;
    localparam logic [11:0] ADDR_STATUS = 12'h104;
    localparam logic [11:0] ADDR_MASK = 12'h108;
    localparam logic [15:0] CAP_ID_VALUE = 16'h0001;
    localparam logic [11:0] NEXT_PTR_END = 12'h000;
    localparam logic [11:0] NEXT_PTR_VC = 12'h150;
    localparam logic [3:0] CAP_VERSION = 4'h1;
    localparam int NUM_ERR = 10;
    localparam int BIT_UR = 20;
    localparam int BIT_ECRC = 19;
    localparam int BIT_MAL = 18;
    localparam int BIT_OVF = 17;
    localparam int BIT_UNXP = 16;
    localparam int BIT_CA = 15;
    localparam int BIT_CTO = 14;
    localparam int BIT_FC = 13;
    localparam int BIT_PSN = 12;
    localparam int BIT_DLL = 4;
    // Writable / settable bits: 20..12 and 4
    localparam logic [31:0] IMPL_BITS = 32'h001F_F010;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Per-event detection pulses, index order fixed by err_bit_pos
    typedef struct packed {
        logic unsupported_request;
        logic end_to_end_crc;
        logic malformed_packet;
        logic receiver_overflow;
        logic unmatched_completion;
        logic completer_abort;
        logic completion_expiry;
        logic credit_protocol_fault;
        logic poisoned_packet;
        logic link_protocol;
    } err_pulse_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cfg_req_t;

    function automatic int err_bit_pos(input int idx);
        case (idx)
            9: err_bit_pos = BIT_UR;
            8: err_bit_pos = BIT_ECRC;
            7: err_bit_pos = BIT_MAL;
            6: err_bit_pos = BIT_OVF;
            5: err_bit_pos = BIT_UNXP;
            4: err_bit_pos = BIT_CA;
            3: err_bit_pos = BIT_CTO;
            2: err_bit_pos = BIT_FC;
            1: err_bit_pos = BIT_PSN;
            default: err_bit_pos = BIT_DLL;
        endcase
    endfunction
endpackage

// file: design/uerr_event_map.sv
// Spreads the detection pulses onto their status bit positions
// Assumes every input is a one-cycle pulse synchronous to the core clock
`timescale 1ns/1ps
module uerr_event_map (
    input wire uerr_pkg::err_pulse_t pulses_i,
    output logic [31:0] events_o
);
    logic [uerr_pkg::NUM_ERR-1:0] flat;
    assign flat = pulses_i;
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_bit
            logic hit;
            always_comb begin
                hit = 1'b0;
                for (int k = 0; k < uerr_pkg::NUM_ERR; k++) begin
                    if (uerr_pkg::err_bit_pos(k) == g) begin
                        hit = flat[k];
                    end
                end
            end
            assign events_o[g] = hit;
        end
    endgenerate
endmodule

// file: design/uerr_next_cap.sv
// Builds the capability header words: identifier and next pointer with version
// Assumes the channel-structure enable comes from the bridge's general control register
`timescale 1ns/1ps
module uerr_next_cap (
    input wire logic channel_structure_present_enable_i,
    output logic [15:0] cap_id_o,
    output logic [15:0] next_cap_o
);
    assign cap_id_o = uerr_pkg::CAP_ID_VALUE;
    assign next_cap_o = {channel_structure_present_enable_i ? uerr_pkg::NEXT_PTR_VC : uerr_pkg::NEXT_PTR_END,
                         uerr_pkg::CAP_VERSION};
endmodule

// file: design/uerr_report_regs.sv
// Contract
// - VC disabled: next pointer reads 000h
// - VC enabled: next pointer reads 150h
// - Version 1h, whole pointer register read-only
// - Status cleared only by writing ones
// - Unsupported request sets bit 20
// - End-to-end CRC error sets bit 19
// - Malformed packet sets bit 18
// - Credit overrun sets bit 17
// - Unmatched completion sets bit 16
// - Bridge completer abort sets bit 15
// - Completion timeout sets bit 14
// - Flow control protocol error sets bit 13
// - Poisoned packet sets bit 12
// - Link protocol error sets bit 4
// - Reserved bits read zero, ignore writes
// - Masked error never sets its status
// - Mask bits 20:12 and 4 read/write
// - Status and mask reset to zero
// - Capability identifier reads 0001h
//
// Uncorrectable error status/mask registers with capability header.
// Assumes a dword configuration port: addresses are byte offsets, reads
// answer one cycle later with rd_valid_o.
`timescale 1ns/1ps
module uerr_report_regs (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic channel_structure_present_enable_i,
    input wire uerr_pkg::cfg_req_t cfg_i,
    input wire uerr_pkg::err_pulse_t err_i,
    output logic [31:0] rd_data_o,
    output logic rd_valid_o,
    output logic [31:0] status_o,
    output logic [31:0] mask_o,
    output logic [31:0] reported_o
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] mask;
        logic [31:0] rdata;
        logic rvalid;
        logic [31:0] reported;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic [31:0] events;
    logic [15:0] cap_id;
    logic [15:0] next_cap;
    logic [31:0] unmasked;
    logic [31:0] clr;

    // ==========================================================
    // Submodules
    uerr_event_map u_map (
        .pulses_i(err_i),
        .events_o(events)
    );

    uerr_next_cap u_cap (
        .channel_structure_present_enable_i(channel_structure_present_enable_i),
        .cap_id_o(cap_id),
        .next_cap_o(next_cap)
    );

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        // Mask gates the event before it reaches the sticky bit
        unmasked = events & ~state_q.mask & uerr_pkg::IMPL_BITS;
        clr = '0;
        state_d.rvalid = 1'b0;
        state_d.reported = unmasked;
        if (cfg_i.wr) begin
            case (cfg_i.addr)
                uerr_pkg::ADDR_STATUS: begin
                    clr = cfg_i.wdata & uerr_pkg::IMPL_BITS;
                end
                uerr_pkg::ADDR_MASK: begin
                    state_d.mask = cfg_i.wdata & uerr_pkg::IMPL_BITS;
                end
                default: begin
                    // Header word and unmapped offsets are read-only
                    clr = '0;
                end
            endcase
        end
        // Set after clear so a same-cycle detection survives
        state_d.status = (state_q.status & ~clr) | unmasked;
        if (cfg_i.rd) begin
            state_d.rvalid = 1'b1;
            case (cfg_i.addr)
                uerr_pkg::ADDR_CAP_ID: begin
                    state_d.rdata = {next_cap, cap_id};
                end
                uerr_pkg::ADDR_NEXT_CAP: begin
                    state_d.rdata = {16'h0000, next_cap};
                end
                uerr_pkg::ADDR_STATUS: begin
                    state_d.rdata = state_q.status & uerr_pkg::IMPL_BITS;
                end
                uerr_pkg::ADDR_MASK: begin
                    state_d.rdata = state_q.mask & uerr_pkg::IMPL_BITS;
                end
                default: begin
                    state_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q.status <= uerr_pkg::STATUS_RESET;
            state_q.mask <= uerr_pkg::MASK_RESET;
            state_q.rdata <= uerr_pkg::RDATA_RESET;
            state_q.rvalid <= 1'b0;
            state_q.reported <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
        end
    end

    assign rd_data_o = state_q.rdata;
    assign rd_valid_o = state_q.rvalid;
    assign status_o = state_q.status;
    assign mask_o = state_q.mask;
    assign reported_o = state_q.reported;
endmodule

// file: sim/uerr_regs_chk_sva.sv
// Checker for the uncorrectable error report registers
// Assumes a bind onto uerr_report_regs, seeing only its ports
`timescale 1ns/1ps
module uerr_regs_chk (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic channel_structure_present_enable_i,
    input wire uerr_pkg::cfg_req_t cfg_i,
    input wire uerr_pkg::err_pulse_t err_i,
    input wire logic [31:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic [31:0] status_o,
    input wire logic [31:0] mask_o,
    input wire logic [31:0] reported_o
);
    // ========================================
    // Helpers
    logic [31:0] ev;
    logic [31:0] clr;
    logic [15:0] nxt;
    assign ev = {11'h000, err_i[9:1], 7'h00, err_i[0], 4'h0};
    assign clr = (cfg_i.wr && cfg_i.addr == 12'h104) ? cfg_i.wdata : 32'h0000_0000;
    assign nxt = {channel_structure_present_enable_i ? 12'h150 : 12'h000, 4'h1};
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    sequence read_of(logic [11:0] a);
        cfg_i.rd && cfg_i.addr == a;
    endsequence
    // ========================================
    // Properties
    a_read_valid_lat: assert property (1'b1 |=> rd_valid_o == $past(cfg_i.rd))
        else $error("read valid not one cycle after read");
    a_next_ptr_value: assert property (read_of(12'h102) |=> rd_data_o[15:0] == $past(nxt))
        else $error("next pointer read wrong");
    a_cap_id_word: assert property (read_of(12'h100) |=> rd_data_o == {$past(nxt), 16'h0001})
        else $error("capability header read wrong");
    a_status_read: assert property (read_of(12'h104) |=> rd_data_o == $past(status_o))
        else $error("status read differs from register");
    // Set beats clear, masked events never land
    a_status_next: assert property (1'b1 |=> status_o == (($past(status_o) & ~$past(clr))
        | ($past(ev) & ~$past(mask_o)))) else $error("status next value wrong");
    a_reported_masked: assert property (1'b1 |=> reported_o == ($past(ev) & ~$past(mask_o)))
        else $error("reported vector wrong");
    a_mask_write: assert property (cfg_i.wr && cfg_i.addr == 12'h108
        |=> mask_o == ($past(cfg_i.wdata) & 32'h001F_F010)) else $error("mask write wrong");
    a_mask_hold: assert property (!(cfg_i.wr && cfg_i.addr == 12'h108) |=> $stable(mask_o))
        else $error("mask changed without write");
    a_reserved_zero: assert property (((status_o | mask_o) & 32'hFFE0_0FEF) == 32'h0000_0000)
        else $error("reserved bit set");
endmodule

// file: sim/tb.sv
// Self-checking testbench for the uncorrectable error report registers
// Assumes the package, design and checker files compile first
`timescale 1ns/1ps
module tb;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic vc_en = 1'b0;
    uerr_pkg::cfg_req_t cfg = '0;
    uerr_pkg::err_pulse_t err = '0;
    logic [31:0] rd_data, status, mask, reported;
    logic rd_valid;
    int err_total = 0;
    int comparisons = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    uerr_report_regs uerr_report_regs_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .channel_structure_present_enable_i(vc_en), .cfg_i(cfg), .err_i(err), .rd_data_o(rd_data),
        .rd_valid_o(rd_valid), .status_o(status), .mask_o(mask), .reported_o(reported));
    // ========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One request and event cycle; outputs settled on return
    task automatic step(input logic [45:0] c, input logic [9:0] e);
        @(posedge sys_clk_i);
        cfg <= c;
        err <= e;
        @(posedge sys_clk_i);
        cfg <= '0;
        err <= '0;
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        step({2'b01, a, d}, 10'h000);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        step({2'b10, a, 32'h0000_0000}, 10'h000);
        check({31'h0, rd_valid}, 32'h0000_0001);
        check(rd_data, exp);
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ========================================
    // Scenarios
    task automatic t_cap;
        #1;
        check(status | mask | rd_data, 32'h0000_0000);
        rd(12'h100, 32'h0001_0001);
        rd(12'h10C, 32'h0000_0000);
        wr(12'h100, 32'hFFFF_FFFF);
        wr(12'h102, 32'hFFFF_FFFF);
        @(posedge sys_clk_i);
        vc_en <= 1'b1;
        rd(12'h100, 32'h1501_0001);
        step({2'b10, 12'h102, 32'h0000_0000}, 10'h000);
        check({16'h0000, rd_data[15:0]}, 32'h0000_1501);
        $display("test capability done");
    endtask
    task automatic t_events;
        for (int i = 0; i < 10; i++) begin
            step(46'h0, 10'h001 << i);
            check(status, 32'h0000_0001 << (i == 0 ? 4 : i + 11));
            check(reported, 32'h0000_0001 << (i == 0 ? 4 : i + 11));
            wr(12'h104, 32'hFFFF_FFFF);
        end
        step(46'h0, 10'h3FF);
        wr(12'h104, 32'h0000_0010);
        rd(12'h104, 32'h001F_F000);
        wr(12'h104, 32'h0000_0000);
        rd(12'h104, 32'h001F_F000);
        $display("test events done");
    endtask
    task automatic t_mask;
        wr(12'h108, 32'hFFFF_FFFF);
        rd(12'h108, 32'h001F_F010);
        wr(12'h104, 32'hFFFF_FFFF);
        step(46'h0, 10'h3FF);
        check(status | reported, 32'h0000_0000);
        wr(12'h108, 32'h0010_0000);
        step(46'h0, 10'h3FF);
        rd(12'h104, 32'h000F_F010);
        wr(12'h108, 32'h0000_0000);
        step({2'b01, 12'h104, 32'hFFFF_FFFF}, 10'h200);
        check(status, 32'h0010_0000);
        // Read and clear in one cycle: read sees the old value
        step({2'b11, 12'h104, 32'hFFFF_FFFF}, 10'h000);
        check(rd_data, 32'h0010_0000);
        check(status, 32'h0000_0000);
        $display("test mask done");
    endtask
    task automatic t_reset;
        wr(12'h108, 32'h0000_0010);
        step(46'h0, 10'h3FF);
        check(status, 32'h001F_F000);
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        #1;
        check(status | mask, 32'h0000_0000);
        check(rd_data, 32'h0000_0000);
        step(46'h0, 10'h001);
        check(status, 32'h0000_0010);
        $display("test reset done");
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_cap;
        t_events;
        t_mask;
        t_reset;
        report_and_stop;
    end
    // Tests need about 120 cycles; 4000 leaves ample margin
    initial begin
        #200us;
        err_total++;
        report_and_stop;
    end
endmodule
bind uerr_report_regs uerr_regs_chk uerr_regs_chk_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .channel_structure_present_enable_i(channel_structure_present_enable_i), .cfg_i(cfg_i),
    .err_i(err_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .status_o(status_o),
    .mask_o(mask_o), .reported_o(reported_o));
